// ---- rtl/dnc_nco_device.sv ----
// nco control port: write capture, tuning and offset registers, phase accumulator
//
// Notes on behaviour
// - select pin picks tuning word increment
// - tuning select sampled each clock edge
// - host changes tuning select away from edges
// - strobe rise captures data and address
// - captured word loaded on next clock
// - late strobe loads one clock later
// - host keeps strobe rise off clock edge
// - address picks the only destination written
// - sixteen data lines only load registers
// - selected offset added before sine lookup
// - offset selects sampled each clock edge
// - host holds offset selects stable at edges
// - sleep low freezes accumulator and phase word, stops converter, reference
// - sleep high resumes normal operation
// - reset low clears accumulator to zero
// - address map: tuning halves, then offsets
// - offset select value picks offset register
// - 32-bit wrapping accumulator adds tuning word
// - offsets take data bits 11..0, top bits
`timescale 1ns/100ps
module dnc_nco_device
   import dnc_pkg::*;
(
   // clock and reset
   input  wire logic                 i_clk,
   input  wire logic                 i_rst,
   // pins from the host
   dnc_nco_if.device                 pins,
   // synthesis outputs
   output logic      [DNC_OFS_W-1:0] o_phase_word,
   output logic      [DNC_ACC_W-1:0] o_phase_accum,
   // power control outputs
   output logic                      o_dac_enable,
   output logic                      o_reference_enable
);
   // ****************************************
   // elaboration checks
   // ****************************************
   // the pin vector layout and the split of a tuning word into halves
   if (DNC_PIN_W != DNC_DATA_W + DNC_ADDR_W + 6) begin : g_chk_pins
      $error("dnc_nco_device: pin vector width does not match its fields");
   end
   if (DNC_ACC_W != 2 * DNC_DATA_W) begin : g_chk_halves
      $error("dnc_nco_device: tuning word must be two data words");
   end
   // offsets come from the data bus and land on the top accumulator bits
   if (DNC_OFS_W > DNC_DATA_W || DNC_OFS_W > DNC_ACC_W) begin : g_chk_ofs
      $error("dnc_nco_device: offset wider than its source or target");
   end
   if (DNC_NUM_OFS != 4) begin : g_chk_num
      $error("dnc_nco_device: offset select is two bits, four registers");
   end

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic                                   wr_prev;    // last synced strobe level
      logic                                   hold_valid; // holding stage full
      logic [DNC_ADDR_W-1:0]                  hold_addr;
      logic [DNC_DATA_W-1:0]                  hold_data;
      logic [1:0][DNC_ACC_W-1:0]              tuning;     // tuning words 0 and 1
      logic [DNC_NUM_OFS-1:0][DNC_OFS_W-1:0]  offset;     // offset registers 0..3
      logic [DNC_ACC_W-1:0]                   accum;
      logic [DNC_OFS_W-1:0]                   phase;
      logic                                   dac_on;
      logic                                   ref_on;
   } dnc_dev_type;

   dnc_dev_type state;
   dnc_dev_type next_state;

   // ****************************************
   // pin synchronisation
   // ****************************************
   logic [DNC_PIN_W-1:0] pin_raw;
   logic [DNC_PIN_W-1:0] pin_sync;

   // gather every pin into one vector, all pass two flip-flops
   assign pin_raw = {pins.accum_reset_n,
                     pins.sleep_n,
                     pins.offset_select_hi,
                     pins.offset_select_lo,
                     pins.tuning_word_select,
                     pins.write_strobe_n,
                     pins.dest_register_select,
                     pins.write_data_bus};

   dnc_pin_sync #(
      .W         (DNC_PIN_W),
      .RESET_VAL (DNC_PIN_IDLE)
   ) u_pin_sync (
      .i_clk  (i_clk),
      .i_rst  (i_rst),
      .i_pins (pin_raw),
      .o_pins (pin_sync)
   );

   // decoded synchronised pins
   logic                  wr_n_s;
   logic [DNC_DATA_W-1:0] data_s;
   logic [DNC_ADDR_W-1:0] addr_s;
   logic                  tws_s;
   logic [1:0]            osel_s;
   logic                  awake_s;
   logic                  acc_clr_s;
   logic                  wr_rise;

   assign wr_n_s    = pin_sync[DNC_PIN_WR_N];
   assign data_s    = pin_sync[DNC_PIN_DATA +: DNC_DATA_W];
   assign addr_s    = pin_sync[DNC_PIN_ADDR +: DNC_ADDR_W];
   assign tws_s     = pin_sync[DNC_PIN_TWS];
   assign osel_s    = {pin_sync[DNC_PIN_OSHI], pin_sync[DNC_PIN_OSLO]};
   assign awake_s   = pin_sync[DNC_PIN_SLP_N];
   assign acc_clr_s = ~pin_sync[DNC_PIN_RST_N];

   // one pulse per low-to-high strobe transition
   assign wr_rise = wr_n_s & ~state.wr_prev;

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      logic [DNC_ACC_W-1:0] step;
      logic [DNC_OFS_W-1:0] ofs_sel;
      next_state = state;
      step       = '0;
      ofs_sel    = '0;

      // edge tracking of the strobe
      next_state.wr_prev = wr_n_s;

      // capture data and address into the holding stage on strobe rise
      next_state.hold_valid = wr_rise;
      if (wr_rise) begin
         next_state.hold_addr = addr_s;
         next_state.hold_data = data_s;
      end

      // move the held word into its destination on the following edge
      if (state.hold_valid) begin
         if (state.hold_addr[DNC_ADDR_OFS_BIT]) begin
            // upper half of the map: one of the offset registers
            next_state.offset[state.hold_addr[1:0]] =
               state.hold_data[DNC_OFS_W-1:0];
         end else begin
            unique case (state.hold_addr)
               DNC_ADDR_TW0_LO: begin
                  next_state.tuning[0][DNC_DATA_W-1:0] = state.hold_data;
               end
               DNC_ADDR_TW0_HI: begin
                  next_state.tuning[0][DNC_ACC_W-1:DNC_DATA_W] = state.hold_data;
               end
               DNC_ADDR_TW1_LO: begin
                  next_state.tuning[1][DNC_DATA_W-1:0] = state.hold_data;
               end
               DNC_ADDR_TW1_HI: begin
                  next_state.tuning[1][DNC_ACC_W-1:DNC_DATA_W] = state.hold_data;
               end
               default: begin
                  next_state.hold_data = state.hold_data;
               end
            endcase
         end
      end

      // increment chosen by the synced tuning select
      step = tws_s ? state.tuning[1] : state.tuning[0];
      // offset chosen by the synced offset selects
      ofs_sel = state.offset[osel_s];

      // accumulator: reset pin clears, sleep freezes, else free running
      if (acc_clr_s) begin
         next_state.accum = DNC_ACC_RESET;
      end else if (awake_s) begin
         next_state.accum = state.accum + step;
      end

      // phase word sent to the lookup: top accumulator bits plus offset
      if (awake_s) begin
         next_state.phase = state.accum[DNC_ACC_W-1 -: DNC_OFS_W] + ofs_sel;
      end

      // converter and reference follow the sleep pin
      next_state.dac_on = awake_s;
      next_state.ref_on = awake_s;
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state         <= '0;
         state.wr_prev <= 1'b1;   // strobe idles high, no false rise after reset
      end else begin
         state <= next_state;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign o_phase_word       = state.phase;
   assign o_phase_accum      = state.accum;
   assign o_dac_enable       = state.dac_on;
   assign o_reference_enable = state.ref_on;
endmodule : dnc_nco_device

// ---- rtl/dnc_pkg.sv ----
// shared constants for the nco control port: widths, addresses, pin layout, timing
package dnc_pkg;
   // ****************************************
   // data path widths
   // ****************************************
   localparam int DNC_DATA_W = 16;            // write data bus width
   localparam int DNC_ADDR_W = 3;             // destination select width
   localparam int DNC_ACC_W  = 32;            // phase accumulator width
   localparam int DNC_OFS_W  = 12;            // phase offset width
   localparam int DNC_NUM_OFS = 4;            // number of offset registers

   // ****************************************
   // destination addresses
   // ****************************************
   localparam logic [2:0] DNC_ADDR_TW0_LO = 3'h0;
   localparam logic [2:0] DNC_ADDR_TW0_HI = 3'h1;
   localparam logic [2:0] DNC_ADDR_TW1_LO = 3'h2;
   localparam logic [2:0] DNC_ADDR_TW1_HI = 3'h3;
   localparam int         DNC_ADDR_OFS_BIT = 2; // set for addresses 4..7, offset registers 0..3

   // ****************************************
   // synchronised pin vector layout
   // ****************************************
   localparam int DNC_PIN_DATA  = 0;          // bits 15..0
   localparam int DNC_PIN_ADDR  = 16;         // bits 18..16
   localparam int DNC_PIN_WR_N  = 19;
   localparam int DNC_PIN_TWS   = 20;
   localparam int DNC_PIN_OSLO  = 21;
   localparam int DNC_PIN_OSHI  = 22;
   localparam int DNC_PIN_SLP_N = 23;
   localparam int DNC_PIN_RST_N = 24;
   localparam int DNC_PIN_W     = 25;
   // idle pins: strobe, sleep and reset high, everything else low
   localparam logic [24:0] DNC_PIN_IDLE = 25'h188_0000;

   // ****************************************
   // reset values and host strobe timing
   // ****************************************
   localparam logic [31:0] DNC_ACC_RESET   = 32'h0000_0000;
   localparam int          DNC_WR_LOW_CYC  = 2; // strobe low time, cycles
   localparam int          DNC_WR_HOLD_CYC = 4; // data hold after strobe rise
   localparam int          DNC_HOLD_MIN    = 2; // least hold the device needs
endpackage : dnc_pkg

// ---- rtl/dnc_nco_if.sv ----
// pin interface between the host end and the nco control port
`timescale 1ns/100ps
interface dnc_nco_if;
   logic        write_strobe_n;        // write strobe, data taken on rise
   logic [15:0] write_data_bus;        // write data
   logic [2:0]  dest_register_select;  // destination register
   logic        tuning_word_select;    // picks tuning word 0 or 1
   logic        offset_select_lo;      // offset select, low bit
   logic        offset_select_hi;      // offset select, high bit
   logic        sleep_n;               // low power request
   logic        accum_reset_n;         // clears phase accumulator

   // ****************************************
   // one modport per party
   // ****************************************
   modport device (
      input write_strobe_n, write_data_bus, dest_register_select,
      input tuning_word_select, offset_select_lo, offset_select_hi,
      input sleep_n, accum_reset_n
   );
   modport host (
      output write_strobe_n, write_data_bus, dest_register_select,
      output tuning_word_select, offset_select_lo, offset_select_hi,
      output sleep_n, accum_reset_n
   );
endinterface : dnc_nco_if

// ---- rtl/dnc_pin_sync.sv ----
// two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/100ps
module dnc_pin_sync #(
   parameter int                 W          = 1,
   parameter logic [W-1:0]       RESET_VAL  = '0
) (
   // clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   // pins in, synchronised out
   input  wire logic [W-1:0] i_pins,
   output logic      [W-1:0] o_pins
);
   // ****************************************
   // parameter check
   // ****************************************
   if (W < 1) begin : g_chk
      $error("dnc_pin_sync: width must be at least one");
   end

   typedef struct packed {
      logic [W-1:0] meta;     // first stage, read only by the second
      logic [W-1:0] stable;   // second stage
   } dnc_sync_type;

   dnc_sync_type state;
   dnc_sync_type next_state;

   // shift pins through both stages
   always_comb begin
      next_state.meta   = i_pins;
      next_state.stable = state.meta;
   end

   // register the stages
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state <= {RESET_VAL, RESET_VAL};
      end else begin
         state <= next_state;
      end
   end

   assign o_pins = state.stable;
endmodule : dnc_pin_sync

// ---- rtl/dnc_nco_host.sv ----
// host end: drives the write port and the select, sleep and reset pins
`timescale 1ns/100ps
module dnc_nco_host
   import dnc_pkg::*;
#(
   parameter int LOW_CYCLES  = DNC_WR_LOW_CYC,
   parameter int HOLD_CYCLES = DNC_WR_HOLD_CYC
) (
   // clock and reset
   input  wire logic                  i_clk,
   input  wire logic                  i_rst,
   // write requests from the user
   input  wire logic                  i_write_req,
   input  wire logic [DNC_ADDR_W-1:0] i_write_addr,
   input  wire logic [DNC_DATA_W-1:0] i_write_data,
   output logic                       o_write_busy,
   // level controls from the user
   input  wire logic                  i_tuning_word_select,
   input  wire logic [1:0]            i_offset_select,
   input  wire logic                  i_sleep,
   input  wire logic                  i_accum_reset,
   // pins to the device
   dnc_nco_if.host                    pins
);
   // ****************************************
   // parameter check
   // ****************************************
   if (LOW_CYCLES < 1 || LOW_CYCLES > 255 || HOLD_CYCLES < DNC_HOLD_MIN || HOLD_CYCLES > 255) begin : g_chk
      $error("dnc_nco_host: strobe timing out of range");
   end

   localparam logic [7:0] LOW_LAST  = 8'(LOW_CYCLES - 1);
   localparam logic [7:0] HOLD_LAST = 8'(HOLD_CYCLES - 1);

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_STROBE = 3'b010,
      ST_HOLD   = 3'b100
   } dnc_hst_st_type;

   typedef struct packed {
      dnc_hst_st_type        st;
      logic [7:0]            cnt;
      logic                  wr_n;
      logic [DNC_ADDR_W-1:0] addr;
      logic [DNC_DATA_W-1:0] data;
      logic                  tws;
      logic [1:0]            osel;
      logic                  sleep_n;
      logic                  rst_n;
      logic                  busy;
   } dnc_host_type;

   dnc_host_type state;
   dnc_host_type next_state;

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      next_state = state;
      // level pins change right after our edge, never on it
      next_state.tws     = i_tuning_word_select;
      next_state.osel    = i_offset_select;
      next_state.sleep_n = ~i_sleep;
      next_state.rst_n   = ~i_accum_reset;

      unique case (state.st)
         ST_IDLE: begin
            if (i_write_req) begin
               next_state.st   = ST_STROBE;
               next_state.cnt  = '0;
               next_state.wr_n = 1'b0;
               next_state.addr = i_write_addr;
               next_state.data = i_write_data;
               next_state.busy = 1'b1;
            end
         end
         ST_STROBE: begin
            next_state.cnt = state.cnt + 8'h01;
            if (state.cnt == LOW_LAST) begin
               next_state.st   = ST_HOLD;
               next_state.cnt  = '0;
               next_state.wr_n = 1'b1;
            end
         end
         ST_HOLD: begin
            // address and data stay put until the device has taken them
            next_state.cnt = state.cnt + 8'h01;
            if (state.cnt == HOLD_LAST) begin
               next_state.st   = ST_IDLE;
               next_state.busy = 1'b0;
            end
         end
      endcase
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state         <= '0;
         state.st      <= ST_IDLE;
         state.wr_n    <= 1'b1;
         state.sleep_n <= 1'b1;
         state.rst_n   <= 1'b1;
      end else begin
         state <= next_state;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign pins.write_strobe_n       = state.wr_n;
   assign pins.write_data_bus       = state.data;
   assign pins.dest_register_select = state.addr;
   assign pins.tuning_word_select   = state.tws;
   assign pins.offset_select_lo     = state.osel[0];
   assign pins.offset_select_hi     = state.osel[1];
   assign pins.sleep_n              = state.sleep_n;
   assign pins.accum_reset_n        = state.rst_n;
   assign o_write_busy              = state.busy;
endmodule : dnc_nco_host

// ---- testbench/dnc_nco_properties.sv ----
// assertions on the nco pin link and the device outputs
`timescale 1ns/100ps
module dnc_nco_properties
   import dnc_pkg::*;
(
   // clock and reset
   input wire logic        i_clk,
   input wire logic        i_rst,
   // link pins
   input wire logic        write_strobe_n,
   input wire logic [15:0] write_data_bus,
   input wire logic [2:0]  dest_register_select,
   input wire logic        tuning_word_select,
   input wire logic        offset_select_lo,
   input wire logic        offset_select_hi,
   input wire logic        sleep_n,
   input wire logic        accum_reset_n,
   // device outputs
   input wire logic [11:0] o_phase_word,
   input wire logic [31:0] o_phase_accum,
   input wire logic        o_dac_enable,
   input wire logic        o_reference_enable
);
   // ****************************************
   // shadow of written registers
   // ****************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   logic [1:0][31:0] tw_sh;
   logic [3:0][11:0] ofs_sh;
   logic [3:0]       prev;     // strobe, tuning select, offset selects
   logic [3:0]       quiet;    // cycles since last pin event
   logic             rose;
   logic             ev;
   logic [11:0]      acc_top;
   // event decode
   assign acc_top = o_phase_accum[31:20];
   assign rose    = write_strobe_n & ~prev[3];
   assign ev      = rose | ~sleep_n | ~accum_reset_n |
                    ({tuning_word_select, offset_select_hi, offset_select_lo} != prev[2:0]);
   // follow writes and time since the last event
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         tw_sh  <= '0;
         ofs_sh <= '0;
         prev   <= 4'h8;
         quiet  <= 4'h0;
      end else begin
         prev  <= {write_strobe_n, tuning_word_select, offset_select_hi, offset_select_lo};
         quiet <= ev ? 4'h0 : quiet + {3'h0, quiet != 4'hf};
         if (rose && dest_register_select[2]) begin
            ofs_sh[dest_register_select[1:0]] <= write_data_bus[11:0];
         end else if (rose && dest_register_select[0]) begin
            tw_sh[dest_register_select[1]][31:16] <= write_data_bus;
         end else if (rose) begin
            tw_sh[dest_register_select[1]][15:0] <= write_data_bus;
         end
      end
   end
   // ****************************************
   // properties
   // ****************************************
   sequence s_strobe_pulse;
      !write_strobe_n [*2] ##1 write_strobe_n;
   endsequence
   sequence s_addr_held;
      ($stable(write_data_bus) && $stable(dest_register_select)) [*4];
   endsequence
   a_strobe_low_width: assert property ($fell(write_strobe_n) |-> s_strobe_pulse)
      else $error("strobe low time wrong");
   a_data_hold: assert property ($rose(write_strobe_n) |-> s_addr_held)
      else $error("address or data moved after strobe rise");
   a_accum_clear: assert property ((!accum_reset_n) [*4] |-> o_phase_accum == DNC_ACC_RESET)
      else $error("accumulator not cleared");
   a_sleep_off: assert property ((!sleep_n) [*4] |-> !o_dac_enable && !o_reference_enable)
      else $error("converter still on in sleep");
   a_wake_on: assert property (sleep_n [*4] |-> o_dac_enable && o_reference_enable)
      else $error("converter off while awake");
   a_sleep_freeze: assert property ((!sleep_n && accum_reset_n) [*4] |=> $stable(o_phase_accum))
      else $error("accumulator moved in sleep");
   a_accum_step: assert property (quiet > 4'h6 |-> o_phase_accum == $past(o_phase_accum) + tw_sh[prev[2]])
      else $error("accumulator step wrong");
   a_phase_word: assert property (quiet > 4'h6 |-> o_phase_word == 12'($past(acc_top) + ofs_sh[prev[1:0]]))
      else $error("phase word wrong");
endmodule : dnc_nco_properties

// ---- testbench/dnc_nco_control_port_tb.sv ----
// self-checking bench: host and device ends joined by the pin link
`timescale 1ns/100ps
module dnc_nco_control_port_tb
   import dnc_pkg::*;
;
   typedef struct packed {
      logic        tws;
      logic [1:0]  sel;
      logic [31:0] step;
      logic [11:0] ofs;
   } dnc_row_type;
   localparam logic [31:0] TW0 = 32'h0010_0003;
   localparam logic [31:0] TW1 = 32'h0200_0050;
   logic        i_clk, i_rst, i_write_req, o_write_busy;
   logic        i_tuning_word_select, i_sleep, i_accum_reset;
   logic        o_dac_enable, o_reference_enable;
   logic [2:0]  i_write_addr;
   logic [15:0] i_write_data;
   logic [1:0]  i_offset_select;
   logic [11:0] o_phase_word, pw;
   logic [31:0] o_phase_accum, a0, a1;
   logic [31:0] hist [11];
   int          n_mismatch = 0;
   int          num_checks = 0;
   // ordinary cases: selects in, step and offset out
   dnc_row_type rows [8] = '{
      '{1'b0, 2'h0, TW0, 12'h123}, '{1'b1, 2'h1, TW1, 12'h456},
      '{1'b0, 2'h2, TW0, 12'h789}, '{1'b1, 2'h3, TW1, 12'habc},
      '{1'b1, 2'h0, TW1, 12'h123}, '{1'b0, 2'h1, TW0, 12'h456},
      '{1'b1, 2'h2, TW1, 12'h789}, '{1'b0, 2'h3, TW0, 12'habc}};
   // ****************************************
   // ends, link and checker
   // ****************************************
   dnc_nco_if link();
   dnc_nco_host u_dnc_nco_host (.i_clk(i_clk), .i_rst(i_rst), .i_write_req(i_write_req),
      .i_write_addr(i_write_addr), .i_write_data(i_write_data), .o_write_busy(o_write_busy),
      .i_tuning_word_select(i_tuning_word_select), .i_offset_select(i_offset_select),
      .i_sleep(i_sleep), .i_accum_reset(i_accum_reset), .pins(link));
   dnc_nco_device u_dnc_nco_device (.i_clk(i_clk), .i_rst(i_rst), .pins(link),
      .o_phase_word(o_phase_word), .o_phase_accum(o_phase_accum),
      .o_dac_enable(o_dac_enable), .o_reference_enable(o_reference_enable));
   dnc_nco_properties u_dnc_nco_properties (.i_clk(i_clk), .i_rst(i_rst),
      .write_strobe_n(link.write_strobe_n), .write_data_bus(link.write_data_bus),
      .dest_register_select(link.dest_register_select), .tuning_word_select(link.tuning_word_select),
      .offset_select_lo(link.offset_select_lo), .offset_select_hi(link.offset_select_hi),
      .sleep_n(link.sleep_n), .accum_reset_n(link.accum_reset_n), .o_phase_word(o_phase_word),
      .o_phase_accum(o_phase_accum), .o_dac_enable(o_dac_enable), .o_reference_enable(o_reference_enable));
   // ****************************************
   // tasks
   // ****************************************
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : results
   // one user write, waits for the host end to finish
   task automatic host_write(input logic [2:0] addr, input logic [15:0] data);
      int n;
      n = 0;
      @(posedge i_clk);
      i_write_req  <= 1'b1;
      i_write_addr <= addr;
      i_write_data <= data;
      @(posedge i_clk);
      i_write_req <= 1'b0;
      repeat (2) @(posedge i_clk);
      #1;
      while (o_write_busy !== 1'b0 && n < 20) begin
         @(posedge i_clk);
         #1 n++;
      end
      if (n == 20) begin
         n_mismatch++;
         $display("mismatch at %0t: busy got %h expected %h", $time, o_write_busy, 1'b0);
         results();
      end
   endtask : host_write
   // two accumulator samples one clock apart, the phase word taken with the second
   task automatic measure(output logic [31:0] x0, output logic [11:0] xp, output logic [31:0] x1);
      @(posedge i_clk);
      #1 x0 = o_phase_accum;
      @(posedge i_clk);
      #1 xp = o_phase_word;
      x1 = o_phase_accum;
   endtask : measure
   // ****************************************
   // clock and main sequence
   // ****************************************
   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end
   initial begin
      i_rst = 1'b1;
      i_write_req = 1'b0;
      i_write_addr = 3'h0;
      i_write_data = 16'h0000;
      i_tuning_word_select = 1'b0;
      i_offset_select = 2'h0;
      i_sleep = 1'b0;
      i_accum_reset = 1'b0;
      repeat (3) @(posedge i_clk);
      i_rst <= 1'b0;
      repeat (4) @(posedge i_clk);
      #1 check(o_phase_accum, DNC_ACC_RESET);
      check({31'h0, o_dac_enable & o_reference_enable}, 32'h1);
      host_write(3'h0, TW0[15:0]);
      host_write(3'h1, TW0[31:16]);
      host_write(3'h2, TW1[15:0]);
      host_write(3'h3, TW1[31:16]);
      host_write(3'h4, 16'hf123);
      host_write(3'h5, 16'ha456);
      host_write(3'h6, 16'h5789);
      host_write(3'h7, 16'h0abc);
      for (int i = 0; i < 8; i++) begin
         @(posedge i_clk);
         i_tuning_word_select <= rows[i].tws;
         i_offset_select      <= rows[i].sel;
         repeat (10) @(posedge i_clk);
         measure(a0, pw, a1);
         check(a1 - a0, rows[i].step);
         check({20'h0, pw}, {20'h0, 12'(a0[31:20] + rows[i].ofs)});
      end
      $display("test rows done");
      // low half alone, timed from the request edge
      @(posedge i_clk);
      i_write_req  <= 1'b1;
      i_write_addr <= 3'h0;
      i_write_data <= 16'h7777;
      @(posedge i_clk);
      i_write_req <= 1'b0;
      #1 hist[0] = o_phase_accum;
      for (int k = 1; k < 11; k++) begin
         @(posedge i_clk);
         #1 hist[k] = o_phase_accum;
      end
      check(hist[6] - hist[5], TW0);
      check(hist[7] - hist[6], 32'h0010_7777);
      check(hist[8] - hist[7], 32'h0010_7777);
      check(hist[10] - hist[9], 32'h0010_7777);
      @(posedge i_clk);
      i_tuning_word_select <= 1'b1;
      repeat (10) @(posedge i_clk);
      measure(a0, pw, a1);
      check(a1 - a0, TW1);
      $display("test write timing done");
      // accumulator reset pin
      @(posedge i_clk);
      i_accum_reset <= 1'b1;
      repeat (6) @(posedge i_clk);
      #1 check(o_phase_accum, DNC_ACC_RESET);
      @(posedge i_clk);
      i_accum_reset <= 1'b0;
      repeat (10) @(posedge i_clk);
      measure(a0, pw, a1);
      check(a1 - a0, TW1);
      $display("test reset pin done");
      // sleep and wake
      @(posedge i_clk);
      i_sleep <= 1'b1;
      repeat (6) @(posedge i_clk);
      measure(a0, pw, a1);
      check({31'h0, o_dac_enable | o_reference_enable}, 32'h0);
      check(a1, a0);
      // reset pin still clears the accumulator while asleep
      @(posedge i_clk);
      i_accum_reset <= 1'b1;
      repeat (6) @(posedge i_clk);
      #1 check(o_phase_accum, DNC_ACC_RESET);
      @(posedge i_clk);
      i_accum_reset <= 1'b0;
      repeat (6) @(posedge i_clk);
      @(posedge i_clk);
      i_sleep <= 1'b0;
      repeat (10) @(posedge i_clk);
      measure(a0, pw, a1);
      check(a1 - a0, TW1);
      check({31'h0, o_dac_enable & o_reference_enable}, 32'h1);
      $display("test sleep done");
      // second reset in mid-run clears the accumulator and the selected tuning word, accumulator stays at zero
      @(posedge i_clk);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_rst <= 1'b0;
      repeat (6) @(posedge i_clk);
      measure(a0, pw, a1);
      check(a1, DNC_ACC_RESET);
      $display("test second reset done");
      results();
   end
endmodule : dnc_nco_control_port_tb
